// ---- include/uart_modem_defines.vh ----
/*
 * Constants for the channel B modem-pin and reset block:
 * register byte offsets, field positions, reset values and timing.
 * Assumes a 25 MHz core clock and a 32-bit AHB-Lite register bus.
 */
// How it works
// (RL1) Control bit 3 at one enables the interrupt pin and drives user output two low.
// (RL2) Control bit 3 at zero floats the interrupt pin and drives user output two high.
// (RL3) Software using the interrupt pin must not toggle bit 3 as a general output.
// (RL4) Reset held over 40 ns returns all registers and outputs to defaults.
// (RL5) During reset transmit output stays high and receive input is ignored.
// (RL6) Set-ready, carrier-detect and ring inputs are general inputs, no UART effect.
// (RL7) Software raises request-to-send via control bit 1 before auto flow control.
// (RL8) Clear-to-send is a general input, or gates transmission when feature bit 7 set.
// (RL9) Control bit 6 zero: transmit idles high; one: infrared, idles low.
// (RL10) A write to control bit 3 moves user output two and interrupt enable together.
`ifndef UART_MODEM_DEFINES_VH
`define UART_MODEM_DEFINES_VH

`define OFF_TX_DATA 8'h00
`define OFF_MODEM_CTRL 8'h04
`define OFF_FEATURE 8'h08
`define OFF_INT_ENABLE 8'h0c
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_MASK 8'h14
`define OFF_PIN_STATUS 8'h18
`define OFF_BAUD_DIV 8'h1c
`define OFF_LINE_STATUS 8'h20

`define MC_TERM_READY 0
`define MC_REQ_SEND 1
`define MC_USER_OUT2 3
`define MC_INFRARED 6
`define MC_WMASK 8'h4b
`define FEAT_AUTO_RTS 6
`define FEAT_AUTO_CTS 7
`define FEAT_WMASK 8'hc0
`define IEN_WMASK 8'hc0

`define EV_CTS 0
`define EV_DSR 1
`define EV_CD 2
`define EV_RI 3
`define EV_TX_DONE 4
`define EV_W 5

`define PS_CTS 0
`define PS_DSR 1
`define PS_CD 2
`define PS_RI 3
`define PS_RX 4
`define LS_TX_BUSY 0
`define LS_HOLD_FULL 1

`define MODEM_CTRL_RST 8'h00
`define FEATURE_RST 8'h00
`define INT_ENABLE_RST 8'h00
`define IRQ_MASK_RST 5'h00
`define BAUD_DIV_RST 16'h0010

`define CLK_PERIOD_NS 40
`define RESET_MIN_NS 40
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- src/modem_pin_sync.v ----
/*
 * Two-flop synchroniser for a group of asynchronous pin inputs.
 * Assumes pins idle high; each bit is synchronised on its own.
 */
`timescale 1ns/100ps
module modem_pin_sync #(
    parameter WIDTH = 5
) (
    input wire clock_i,
    input wire srst_i,
    input wire [WIDTH-1:0] pins_i,
    output wire [WIDTH-1:0] pins_o
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // first stage is read by the second stage only
    always @(posedge clock_i) begin
        if (srst_i) begin
            meta_r <= {WIDTH{1'b1}};
            sync_r <= {WIDTH{1'b1}};
        end else begin
            meta_r <= pins_i;
            sync_r <= meta_r;
        end
    end

    assign pins_o = sync_r;
endmodule // modem_pin_sync

// ---- src/uart_modem_pins.v ----
/*
 * Channel B modem pins, user output two, interrupt pin enable and a
 * small 8N1 transmitter with clear-to-send gating and infrared idle.
 * Assumes a single AHB-Lite master, word transfers, 25 MHz clock.
 */
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "uart_modem_defines.vh"
module uart_modem_pins #(
    parameter [15:0] BAUD_DIV_RST = `BAUD_DIV_RST
) (
    input wire clock_i,
    input wire srst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    input wire serial_receive_in_i,
    input wire clear_to_send_in_n_i,
    input wire set_ready_in_n_i,
    input wire carrier_detect_in_n_i,
    input wire ring_indicator_in_n_i,
    output wire serial_transmit_out_o,
    output wire request_to_send_out_n_o,
    output wire terminal_ready_out_n_o,
    output wire user_output_two_n_o,
    output wire channel_interrupt_out_o,
    output wire channel_interrupt_oe_o
);
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_START = 2'd1;
    localparam [1:0] ST_DATA = 2'd2;
    localparam [1:0] ST_STOP = 2'd3;

    // bus side
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    reg [31:0] hrdata_r;
    reg hready_r;
    reg [31:0] rd_mux;
    wire take;

    // registers
    reg [7:0] mc_r;
    reg [7:0] mc_nxt;
    reg [7:0] feat_r;
    reg [7:0] feat_nxt;
    reg [7:0] ien_r;
    reg [7:0] ien_nxt;
    reg [`EV_W-1:0] sts_r;
    reg [`EV_W-1:0] sts_nxt;
    reg [`EV_W-1:0] mask_r;
    reg [`EV_W-1:0] mask_nxt;
    reg [15:0] div_r;
    reg [15:0] div_nxt;
    reg [7:0] hold_r;
    reg [7:0] hold_nxt;
    reg full_r;
    reg full_nxt;

    // pins
    wire [4:0] pins_s;
    reg [3:0] pins_d_r;
    wire [`EV_W-1:0] ev;

    // transmitter
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [15:0] cnt_r;
    reg [15:0] cnt_nxt;
    reg [2:0] bit_r;
    reg [2:0] bit_nxt;
    reg [7:0] sh_r;
    reg [7:0] sh_nxt;
    reg tx_done;
    wire [15:0] div_eff;
    wire [15:0] qtr;
    wire [15:0] elapsed;
    wire cts_ok;
    reg line_bit;

    // output flops
    reg tx_r;
    reg rts_n_r;
    reg dtr_n_r;
    reg op2_n_r;
    reg int_r;
    reg int_oe_r;

    wire we_tx;
    wire we_mc;
    wire we_feat;
    wire we_ien;
    wire we_sts;
    wire we_mask;
    wire we_div;

    function wr_hit;
        input pend;
        input [7:0] addr;
        input [7:0] off;
        begin
            wr_hit = pend && (addr == off);
        end
    endfunction

    // (RL5) receive and modem inputs held idle in reset
    modem_pin_sync #(
        .WIDTH(5)
    ) u_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .pins_i({serial_receive_in_i, ring_indicator_in_n_i, carrier_detect_in_n_i,
                 set_ready_in_n_i, clear_to_send_in_n_i}),
        .pins_o(pins_s)
    );

    // transfers of any size are decoded as words; size is not checked
    assign take = hsel_i & hready_i & htrans_i[1];

    assign we_tx = wr_hit(wr_pend_r, wr_addr_r, `OFF_TX_DATA);
    assign we_mc = wr_hit(wr_pend_r, wr_addr_r, `OFF_MODEM_CTRL);
    assign we_feat = wr_hit(wr_pend_r, wr_addr_r, `OFF_FEATURE);
    assign we_ien = wr_hit(wr_pend_r, wr_addr_r, `OFF_INT_ENABLE);
    assign we_sts = wr_hit(wr_pend_r, wr_addr_r, `OFF_IRQ_STATUS);
    assign we_mask = wr_hit(wr_pend_r, wr_addr_r, `OFF_IRQ_MASK);
    assign we_div = wr_hit(wr_pend_r, wr_addr_r, `OFF_BAUD_DIV);

    // (RL6) set-ready, carrier-detect and ring inputs only raise status, never steer the line
    assign ev[`EV_CTS] = pins_s[`PS_CTS] ^ pins_d_r[0];
    assign ev[`EV_DSR] = pins_s[`PS_DSR] ^ pins_d_r[1];
    assign ev[`EV_CD] = pins_s[`PS_CD] ^ pins_d_r[2];
    assign ev[`EV_RI] = pins_s[`PS_RI] ^ pins_d_r[3];
    assign ev[`EV_TX_DONE] = tx_done;

    // (RL8) auto clear-to-send gates only the start of a character
    assign cts_ok = ~feat_r[`FEAT_AUTO_CTS] | ~pins_s[`PS_CTS];

    // zero divisor would stall the bit timer
    assign div_eff = (div_r == 16'h0000) ? 16'h0001 : div_r;
    assign qtr = (div_eff[15:2] == 14'h0000) ? 16'h0001 : {2'b00, div_eff[15:2]};
    assign elapsed = div_eff - 16'h0001 - cnt_r;

    always @* begin
        mc_nxt = we_mc ? (hwdata_i[7:0] & `MC_WMASK) : mc_r;
        feat_nxt = we_feat ? (hwdata_i[7:0] & `FEAT_WMASK) : feat_r;
        ien_nxt = we_ien ? (hwdata_i[7:0] & `IEN_WMASK) : ien_r;
        mask_nxt = we_mask ? hwdata_i[`EV_W-1:0] : mask_r;
        div_nxt = we_div ? hwdata_i[15:0] : div_r;
        // set wins over write-one-to-clear
        sts_nxt = (sts_r & ~(we_sts ? hwdata_i[`EV_W-1:0] : {`EV_W{1'b0}})) | ev;
    end

    always @* begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        tx_done = 1'b0;
        hold_nxt = hold_r;
        full_nxt = full_r;
        case (st_r)
            ST_IDLE: begin
                if (full_r && cts_ok) begin
                    st_nxt = ST_START;
                    sh_nxt = hold_r;
                    full_nxt = 1'b0;
                    cnt_nxt = div_eff - 16'h0001;
                end
            end
            ST_START: begin
                if (cnt_r == 16'h0000) begin
                    st_nxt = ST_DATA;
                    bit_nxt = 3'd0;
                    cnt_nxt = div_eff - 16'h0001;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            ST_DATA: begin
                if (cnt_r == 16'h0000) begin
                    cnt_nxt = div_eff - 16'h0001;
                    sh_nxt = {1'b0, sh_r[7:1]};
                    bit_nxt = bit_r + 3'd1;
                    if (bit_r == 3'd7) begin
                        st_nxt = ST_STOP;
                    end
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            ST_STOP: begin
                if (cnt_r == 16'h0000) begin
                    st_nxt = ST_IDLE;
                    tx_done = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        // a write while the holding byte is full is dropped
        if (we_tx && !full_r) begin
            hold_nxt = hwdata_i[7:0];
            full_nxt = 1'b1;
        end
    end

    always @* begin
        case (st_r)
            ST_START: line_bit = 1'b0;
            ST_DATA: line_bit = sh_r[0];
            default: line_bit = 1'b1;
        endcase
    end

    // read data from next values so a read right after a write is fresh
    always @* begin
        rd_mux = 32'h0000_0000;
        case (haddr_i[7:0])
            `OFF_MODEM_CTRL: rd_mux[7:0] = mc_nxt;
            `OFF_FEATURE: rd_mux[7:0] = feat_nxt;
            `OFF_INT_ENABLE: rd_mux[7:0] = ien_nxt;
            `OFF_IRQ_STATUS: rd_mux[`EV_W-1:0] = sts_nxt;
            `OFF_IRQ_MASK: rd_mux[`EV_W-1:0] = mask_nxt;
            `OFF_PIN_STATUS: rd_mux[4:0] = pins_s;
            `OFF_BAUD_DIV: rd_mux[15:0] = div_nxt;
            `OFF_LINE_STATUS: rd_mux[1:0] = {full_nxt, st_nxt != ST_IDLE};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hready_r <= 1'b1;
        end else begin
            wr_pend_r <= take & hwrite_i;
            if (take) begin
                wr_addr_r <= haddr_i[7:0];
            end
            hrdata_r <= (take & ~hwrite_i) ? rd_mux : 32'h0000_0000;
            hready_r <= 1'b1;
        end
    end

    // (RL4) every register returns to default in one reset cycle
    always @(posedge clock_i) begin
        if (srst_i) begin
            mc_r <= `MODEM_CTRL_RST;
            feat_r <= `FEATURE_RST;
            ien_r <= `INT_ENABLE_RST;
            sts_r <= {`EV_W{1'b0}};
            mask_r <= `IRQ_MASK_RST;
            div_r <= BAUD_DIV_RST;
            hold_r <= 8'h00;
            full_r <= 1'b0;
            pins_d_r <= 4'hf;
            st_r <= ST_IDLE;
            cnt_r <= 16'h0000;
            bit_r <= 3'd0;
            sh_r <= 8'h00;
        end else begin
            mc_r <= mc_nxt;
            feat_r <= feat_nxt;
            ien_r <= ien_nxt;
            sts_r <= sts_nxt;
            mask_r <= mask_nxt;
            div_r <= div_nxt;
            hold_r <= hold_nxt;
            full_r <= full_nxt;
            pins_d_r <= pins_s[3:0];
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            // (RL5) transmit held high in reset
            tx_r <= 1'b1;
            rts_n_r <= 1'b1;
            dtr_n_r <= 1'b1;
            op2_n_r <= 1'b1;
            int_r <= 1'b0;
            int_oe_r <= 1'b0;
        end else begin
            // (RL9) infrared pulses zeros in the first quarter, idles low
            if (mc_r[`MC_INFRARED]) begin
                tx_r <= ~line_bit & (elapsed < qtr);
            end else begin
                tx_r <= line_bit;
            end
            // (RL7) request-to-send follows control bit 1 only
            rts_n_r <= ~mc_nxt[`MC_REQ_SEND];
            dtr_n_r <= ~mc_nxt[`MC_TERM_READY];
            // (RL1) (RL2) (RL10) one edge updates both from bit 3
            op2_n_r <= ~mc_nxt[`MC_USER_OUT2];
            int_oe_r <= mc_nxt[`MC_USER_OUT2];
            // (RL3) pin level stays valid even while floated
            int_r <= |(sts_nxt & mask_nxt);
        end
    end

    assign hrdata_o = hrdata_r;
    assign hreadyout_o = hready_r;
    assign hresp_o = 1'b0;
    assign serial_transmit_out_o = tx_r;
    assign request_to_send_out_n_o = rts_n_r;
    assign terminal_ready_out_n_o = dtr_n_r;
    assign user_output_two_n_o = op2_n_r;
    assign channel_interrupt_out_o = int_r;
    assign channel_interrupt_oe_o = int_oe_r;
endmodule // uart_modem_pins

// ---- dv/modem_pins_asserts.sv ----
/* checker for the modem pin block: pin, reset and bus relations.
   assumes binding to uart_modem_pins ports, one clock, zero-wait slave */
`timescale 1ns/100ps
`include "uart_modem_defines.vh"
module modem_pins_asserts (
    input wire clock_i,
    input wire srst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire serial_transmit_out_o,
    input wire request_to_send_out_n_o,
    input wire terminal_ready_out_n_o,
    input wire user_output_two_n_o,
    input wire channel_interrupt_out_o,
    input wire channel_interrupt_oe_o
);
    reg wr_mc_r, wr_mk_r, ir_r, sent_r, mask_zero_r;
    wire take = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    // write tracking, one cycle behind the address phase
    always @(posedge clock_i) begin
        if (srst_i) begin
            wr_mc_r <= 1'b0;
            wr_mk_r <= 1'b0;
            ir_r <= 1'b0;
            sent_r <= 1'b0;
            mask_zero_r <= 1'b1;
        end else begin
            wr_mc_r <= take && haddr_i[7:0] == `OFF_MODEM_CTRL;
            wr_mk_r <= take && haddr_i[7:0] == `OFF_IRQ_MASK;
            // any transmit write ends the idle-level check
            if (take && haddr_i[7:0] == `OFF_TX_DATA)
                sent_r <= 1'b1;
            if (wr_mc_r)
                ir_r <= hwdata_i[`MC_INFRARED];
            if (wr_mk_r)
                mask_zero_r <= hwdata_i[4:0] == 5'h00;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    op2_oe_pair_a:
        assert property (user_output_two_n_o == !channel_interrupt_oe_o) else $error("op2 and int enable differ");
    mc_set_a:
        assert property (wr_mc_r && hwdata_i[3] |=> !user_output_two_n_o && channel_interrupt_oe_o)
        else $error("bit 3 set not seen on pins");
    mc_clear_a:
        assert property (wr_mc_r && !hwdata_i[3] |=> user_output_two_n_o && !channel_interrupt_oe_o)
        else $error("bit 3 clear not seen on pins");
    rts_follow_a:
        assert property (wr_mc_r |=> request_to_send_out_n_o == !$past(hwdata_i[1])
            && terminal_ready_out_n_o == !$past(hwdata_i[0])) else $error("rts or dtr wrong");
    reset_outputs_a:
        assert property (disable iff (1'b0) srst_i |=> request_to_send_out_n_o && terminal_ready_out_n_o
            && user_output_two_n_o && !channel_interrupt_oe_o && !channel_interrupt_out_o)
        else $error("outputs not at default in reset");
    reset_tx_high_a:
        assert property (disable iff (1'b0) srst_i |=> serial_transmit_out_o) else $error("tx low in reset");
    idle_level_a:
        assert property ((!sent_r && $stable(ir_r)) [*3] |-> serial_transmit_out_o == !ir_r)
        else $error("tx idle level wrong");
    mask_quiet_a:
        assert property (mask_zero_r && $past(mask_zero_r) |-> !channel_interrupt_out_o)
        else $error("interrupt with all masked");
    bus_okay_a:
        assert property (hreadyout_o && !hresp_o) else $error("bus not ready or error");
    cover property (wr_mc_r && hwdata_i[3]);
    cover property (wr_mc_r && hwdata_i[6]);
    cover property (channel_interrupt_out_o);
endmodule // modem_pins_asserts

// ---- dv/serial_peer.sv ----
/* serial peer model: drives modem status lines, holds receive idle,
   decodes 8N1 frames from the transmit line. assumes normal framing */
`timescale 1ns/100ps
module serial_peer #(
    parameter DIV = 4
) (
    input wire clock_i,
    input wire tx_i,
    input wire listen_i,
    input wire [3:0] lines_i,
    output wire [3:0] lines_n_o,
    output wire rx_o,
    output reg [7:0] byte_o,
    output reg [7:0] count_o
);
    integer i;
    assign lines_n_o = lines_i;
    // nothing sent back, so receive idles high
    assign rx_o = 1'b1;
    initial begin
        byte_o = 8'h00;
        count_o = 8'h00;
    end
    // sample mid-cell; a frame counts only with a high stop bit
    always begin
        @(negedge tx_i);
        if (listen_i) begin
            repeat (DIV + DIV / 2) @(posedge clock_i);
            for (i = 0; i < 8; i = i + 1) begin
                byte_o[i] = tx_i;
                repeat (DIV) @(posedge clock_i);
            end
            if (tx_i)
                count_o = count_o + 8'h01;
        end
    end
endmodule // serial_peer

// ---- dv/uart_modem_pins_and_reset_test.sv ----
/* testbench for uart_modem_pins: AHB-Lite master tasks, serial peer.
   assumes a zero-wait slave and a 25 MHz clock */
`timescale 1ns/100ps
`include "uart_modem_defines.vh"
`define CHK(n, e, a) begin checks_done = checks_done + 1; if ((a) !== (e)) begin fail_count = fail_count + 1; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module uart_modem_pins_and_reset_test;
    localparam DIV = 4;
    reg clock_i = 0, srst_i = 1, hsel_i = 0, hwrite_i = 0, listen = 0;
    reg [1:0] htrans_i = 0;
    reg [3:0] lines = 4'hf;
    reg [31:0] haddr_i = 0, hwdata_i = 0, q, d, r;
    wire [31:0] hrdata_o;
    wire [3:0] ln;
    wire [7:0] rx_byte, rx_count;
    wire hreadyout_o, hresp_o, tx, rx, rts_n, dtr_n, op2_n, irq, irq_oe;
    integer fail_count = 0, checks_done = 0, seed = 32'hc80e, cyc = 0, i, n;
    always #20 clock_i = ~clock_i;
    uart_modem_pins #(.BAUD_DIV_RST(DIV)) uut (.clock_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o,
        .serial_receive_in_i(rx), .clear_to_send_in_n_i(ln[0]), .set_ready_in_n_i(ln[1]),
        .carrier_detect_in_n_i(ln[2]), .ring_indicator_in_n_i(ln[3]), .serial_transmit_out_o(tx),
        .request_to_send_out_n_o(rts_n), .terminal_ready_out_n_o(dtr_n), .user_output_two_n_o(op2_n),
        .channel_interrupt_out_o(irq), .channel_interrupt_oe_o(irq_oe));
    serial_peer #(.DIV(DIV)) peer (.clock_i, .tx_i(tx), .listen_i(listen), .lines_i(lines), .lines_n_o(ln),
        .rx_o(rx), .byte_o(rx_byte), .count_o(rx_count));
    // entered just after a rising edge
    task bus(input w, input [7:0] a, input [31:0] wd);
        begin
            hsel_i <= 1'b1;
            htrans_i <= 2'h2;
            hwrite_i <= w;
            haddr_i <= {24'h0, a};
            @(posedge clock_i);
            while (hreadyout_o !== 1'b1) @(posedge clock_i);
            htrans_i <= 2'h0;
            hwdata_i <= wd;
            @(posedge clock_i);
            while (hreadyout_o !== 1'b1) @(posedge clock_i);
            q = hrdata_o;
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        bus(1'b1, a, v);
    endtask
    task rd(input [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    // dtr_n, rts_n, op2_n, int enable, tx idle level
    function [4:0] pin_exp(input [7:0] m);
        pin_exp = {~m[0], ~m[1], ~m[3], m[3], ~m[6]};
    endfunction
    // other modem lines wander, clear-to-send held at c; a run-out shows as a count mismatch
    task wait_frames(input [7:0] k, input c);
        begin
            for (n = 0; n < 400 && rx_count < k; n = n + 1) begin
                @(posedge clock_i);
                r = $random(seed);
                lines <= {r[3:1], c};
            end
            `CHK("frames seen", k, rx_count)
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    always @(posedge clock_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            conclude;
        end
    end
    initial begin
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        `CHK("reset pins", pin_exp(8'h00), {dtr_n, rts_n, op2_n, irq_oe, tx})
        for (i = 0; i < 16; i = i + 1) begin
            d = (i == 0) ? 32'h08 : (i == 1) ? 32'h00 : $random(seed);
            wr(`OFF_MODEM_CTRL, d);
            rd(`OFF_MODEM_CTRL);
            `CHK("modem ctrl", d & 32'h4b, q)
            `CHK("pins", pin_exp(d[7:0]), {dtr_n, rts_n, op2_n, irq_oe, tx})
        end
        wr(`OFF_MODEM_CTRL, 32'h4b);
        srst_i <= 1'b1;
        @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        `CHK("pins after reset", pin_exp(8'h00), {dtr_n, rts_n, op2_n, irq_oe, tx})
        rd(`OFF_MODEM_CTRL);
        `CHK("ctrl after reset", 32'h0, q)
        wr(`OFF_BAUD_DIV, DIV);
        // rts raised first; bit 3 then left set while the interrupt is used
        wr(`OFF_MODEM_CTRL, 32'h0a);
        wr(`OFF_FEATURE, 32'hc0);
        wr(`OFF_INT_ENABLE, 32'hc0);
        wr(`OFF_IRQ_MASK, 32'h10);
        listen <= 1'b1;
        wr(`OFF_TX_DATA, 32'ha5);
        repeat (60) @(posedge clock_i);
        `CHK("gated frames", 8'h00, rx_count)
        `CHK("gated line", 1'b1, tx)
        rd(`OFF_LINE_STATUS);
        `CHK("hold full", 32'h2, q)
        lines <= 4'he;
        wait_frames(8'h01, 1'b0);
        repeat (2 * DIV) @(posedge clock_i);
        `CHK("cts byte", 8'ha5, rx_byte)
        `CHK("irq raised", 1'b1, irq)
        rd(`OFF_IRQ_STATUS);
        `CHK("done status", 1'b1, q[4])
        wr(`OFF_IRQ_STATUS, 32'h1f);
        rd(`OFF_IRQ_MASK);
        `CHK("irq cleared", 1'b0, irq)
        // cts held high and modem lines wander: no effect with gating off
        wr(`OFF_IRQ_MASK, 32'h0);
        wr(`OFF_FEATURE, 32'h0);
        d = $random(seed);
        wr(`OFF_TX_DATA, d);
        wait_frames(8'h02, 1'b1);
        repeat (2 * DIV) @(posedge clock_i);
        `CHK("free byte", d[7:0], rx_byte)
        `CHK("irq masked", 1'b0, irq)
        // general inputs show up only in the pin and status readouts, receive idles high
        lines <= 4'h5;
        repeat (4) @(posedge clock_i);
        rd(`OFF_PIN_STATUS);
        `CHK("pin status", 32'h15, q)
        // infrared: a zero byte gives nine short high pulses, then idles low
        listen <= 1'b0;
        wr(`OFF_MODEM_CTRL, 32'h48);
        wr(`OFF_TX_DATA, 32'h00);
        n = 0;
        for (i = 0; i < 60; i = i + 1) begin
            @(posedge clock_i);
            if (tx === 1'b1)
                n = n + 1;
        end
        `CHK("ir pulses", 9 * ((DIV / 4 > 0) ? DIV / 4 : 1), n)
        `CHK("ir idle", 1'b0, tx)
        rd(8'h3c);
        `CHK("unmapped read", 32'h0, q)
        conclude;
    end
endmodule // uart_modem_pins_and_reset_test
bind uart_modem_pins modem_pins_asserts chk (.clock_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hready_i, .hwdata_i, .hreadyout_o, .hresp_o, .serial_transmit_out_o, .request_to_send_out_n_o,
    .terminal_ready_out_n_o, .user_output_two_n_o, .channel_interrupt_out_o, .channel_interrupt_oe_o);
